/* File: design/bst_pkg.sv */
package bst_pkg;

    // timing
    localparam int CLK_PERIOD_NS       = 5;
    localparam int BOR_MIN_DURATION_NS = 200;
    localparam int BOR_MIN_CYCLES      =
        (BOR_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BOR_CNT_W           = 8;
    localparam int PLL_WAIT_MS         = 2;
    localparam int PLL_WAIT_CYCLES     = PLL_WAIT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int PLL_CNT_W           = 20;
    localparam int POWERUP_DELAY_TIMER_CNT_W          = 11;
    localparam logic [10:0] POWERUP_DELAY_TIMER_LAST  = 11'h7ff;
    localparam int OST_CNT_W           = 10;
    localparam logic [9:0] OST_LAST    = 10'h3ff;

    // register map
    localparam logic [11:0] ADDR_CTRL  = 12'h000;
    localparam logic [11:0] ADDR_STAT  = 12'h004;
    localparam int BIT_BOR_FLAG        = 0;
    localparam int BIT_POR_FLAG        = 1;
    localparam int BIT_SW_BOR_EN       = 6;
    localparam int STAT_STATE_LSB      = 0;
    localparam int STAT_HOLD           = 6;
    localparam int STAT_DET_EN         = 7;
    localparam int STAT_SUPPLY_LOW     = 8;
    localparam int STAT_MASTER_CLEAR_N           = 9;
    localparam int STAT_THR_LSB        = 10;
    localparam logic RST_BOR_FLAG      = 1'b0;
    localparam logic RST_POR_FLAG      = 1'b0;
    localparam logic RST_SW_BOR_EN     = 1'b1;

    // enable modes
    localparam logic [1:0] BOR_MODE_OFF   = 2'h0;
    localparam logic [1:0] BOR_MODE_SW    = 2'h1;
    localparam logic [1:0] BOR_MODE_NOSLP = 2'h2;
    localparam logic [1:0] BOR_MODE_ON    = 2'h3;

    typedef enum logic [3:0] {
        OSC_LP    = 4'h0,
        OSC_XT    = 4'h1,
        OSC_HS    = 4'h2,
        OSC_HSPLL = 4'h3,
        OSC_XTPLL = 4'h4,
        OSC_EC    = 4'h5,
        OSC_ECPLL = 4'h6,
        OSC_RC    = 4'h7,
        OSC_INT   = 4'h8
    } bst_osc_t;

    typedef enum logic [5:0] {
        ST_POR  = 6'h01,
        ST_BOR  = 6'h02,
        ST_POWERUP_DELAY_TIMER = 6'h04,
        ST_OST  = 6'h08,
        ST_PLL  = 6'h10,
        ST_RUN  = 6'h20
    } bst_state_t;

    typedef struct packed {
        logic [1:0] brownout_enable_mode;
        logic [1:0] brownout_threshold_select;
        logic       powerup_delay_disable_n;
        bst_osc_t   osc_mode;
    } bst_cfg_t;

    typedef struct packed {
        logic       core_reset_hold;
        logic       detector_enable;
        logic [1:0] brownout_threshold;
    } bst_out_t;

endpackage

/* File: design/bst_brownout_and_startup_timers.sv */
// Contract
// - supply low beyond minimum duration resets device only while the detector is enabled
// - brown-out reset holds while supply stays below threshold
// - enabled power-up delay starts after supply recovers, extending reset
// - supply drop during power-up delay re-enters brown-out and restarts delay
// - brown-out enable and power-up delay enable are independent
// - mode 01: software enable bit turns the detector on or fully off
// - software enable bit works only in mode 01, else reads 0
// - threshold comes only from configuration bits, never software
// - with brown-out enabled, brown-out flag cleared by brown-out and power-on
// - mode 10: detector off in sleep, back on when leaving sleep
// - mode 11: detector always on, only configuration disables it
// - power-up delay is 11-bit count of 2048 slow oscillator periods
// - power-up delay enabled when its active-low configuration bit is clear
// - after power-up delay, count 1024 primary oscillator cycles
// - oscillator count only in crystal modes, on power-on or power-managed exit
// - with phase lock loop in use, 2 ms wait follows oscillator count
// - power-up: wait power-on pulse clear, power-up delay, then oscillator count
// - RC mode with power-up delay disabled has no start-up delay
// - delays run regardless of master clear; release follows master clear
// - power-on flag cleared by power-on only, never set by hardware
module bst_brownout_and_startup_timers
    import bst_pkg::*;
#(
    parameter int PLL_WAIT_CYC = bst_pkg::PLL_WAIT_CYCLES
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    input  wire bst_pkg::bst_cfg_t cfg,
    input  wire logic             por_pulse,
    input  wire logic             supply_below_cmp,
    input  wire logic             master_clear_n,
    input  wire logic             sleep_active,
    input  wire logic             pm_exit_wake,
    input  wire logic             low_freq_internal_osc,
    input  wire logic             primary_osc_in,
    output bst_pkg::bst_out_t     status_out
);
    import bst_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // helpers

    function automatic logic mode_needs_ost(input bst_osc_t m);
        return (m == OSC_LP) || (m == OSC_XT) || (m == OSC_HS) ||
               (m == OSC_HSPLL) || (m == OSC_XTPLL);
    endfunction

    function automatic logic mode_uses_pll(input bst_osc_t m);
        return (m == OSC_HSPLL) || (m == OSC_XTPLL) || (m == OSC_ECPLL);
    endfunction

    // state that follows the power-up delay (or its bypass)
    function automatic bst_state_t after_powerup_delay_timer(input logic por_seq,
                                              input bst_osc_t m);
        bst_state_t s;
        s = ST_RUN;
        if (por_seq && mode_needs_ost(m)) begin
            s = ST_OST;
        end else if (por_seq && mode_uses_pll(m)) begin
            s = ST_PLL;
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    bst_state_t               state;
    bst_state_t               next_state;
    logic                     por_seq;
    logic                     cmp_meta;
    logic                     cmp_sync;
    logic [BOR_CNT_W-1:0]     bor_cnt;
    logic [POWERUP_DELAY_TIMER_CNT_W-1:0]    powerup_delay_timer_cnt;
    logic [OST_CNT_W-1:0]     ost_cnt;
    logic [PLL_CNT_W-1:0]     pll_cnt;
    logic                     lf_q;
    logic                     osc_q;
    logic                     brownout_flag_n;
    logic                     poweron_flag_n;
    logic                     sw_brownout_enable;

    ////////////////////////////////////////////////////////////////////////////
    // decode

    wire logic       powerup_delay_timer_enabled = ~cfg.powerup_delay_disable_n;
    wire logic       lf_tick      = low_freq_internal_osc & ~lf_q;
    wire logic       osc_tick     = primary_osc_in & ~osc_q;
    wire logic       sw_mode      = cfg.brownout_enable_mode == BOR_MODE_SW;
    wire logic       sw_en_read   = sw_brownout_enable & sw_mode;
    wire logic       noslp_mode   = cfg.brownout_enable_mode == BOR_MODE_NOSLP;
    wire logic       on_mode      = cfg.brownout_enable_mode == BOR_MODE_ON;

    // detector enable per mode; independent of the power-up delay bit
    wire logic det_enable =
        (sw_mode & sw_brownout_enable) |
        (noslp_mode & ~sleep_active) |
        on_mode;

    wire logic supply_low = det_enable & cmp_sync;
    // short dips below the minimum duration never reach the sequencer
    wire logic bor_trigger =
        supply_low & (bor_cnt == BOR_CNT_W'(BOR_MIN_CYCLES));
    // the power-on state already holds everything, so a dip there changes nothing
    wire logic bor_reset = bor_trigger & (state != ST_POR);

    wire logic powerup_delay_timer_done = lf_tick & (powerup_delay_timer_cnt == POWERUP_DELAY_TIMER_LAST);
    wire logic ost_done  = osc_tick & (ost_cnt == OST_LAST);
    wire logic pll_done  = pll_cnt == PLL_CNT_W'(PLL_WAIT_CYC - 1);

    wire logic       acc       = psel & penable & ~pready;
    wire logic       done_xfer = psel & penable & pready;
    wire logic       hit_ctrl  = paddr == ADDR_CTRL;
    wire logic       hit_stat  = paddr == ADDR_STAT;
    wire logic       wr_ctrl   = done_xfer & pwrite & hit_ctrl;
    wire logic       set_poweron  = wr_ctrl & pwdata[BIT_POR_FLAG];
    wire logic       set_brownout = wr_ctrl & pwdata[BIT_BOR_FLAG];

    logic [31:0] rd_word;
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_word[BIT_BOR_FLAG]  = brownout_flag_n;
            rd_word[BIT_POR_FLAG]  = poweron_flag_n;
            rd_word[BIT_SW_BOR_EN] = sw_en_read;
        end else if (hit_stat) begin
            rd_word[STAT_STATE_LSB +: 6]  = state;
            rd_word[STAT_HOLD]            = status_out.core_reset_hold;
            rd_word[STAT_DET_EN]          = det_enable;
            rd_word[STAT_SUPPLY_LOW]      = supply_low;
            rd_word[STAT_MASTER_CLEAR_N]            = master_clear_n;
            rd_word[STAT_THR_LSB +: 2]    = cfg.brownout_threshold_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    always_comb begin
        next_state = state;
        case (state)
            ST_POR: begin
                if (!por_pulse) begin
                    if (powerup_delay_timer_enabled) begin
                        next_state = ST_POWERUP_DELAY_TIMER;
                    end else begin
                        next_state = after_powerup_delay_timer(1'b1, cfg.osc_mode);
                    end
                end
            end
            ST_BOR: begin
                if (!supply_low) begin
                    if (powerup_delay_timer_enabled) begin
                        next_state = ST_POWERUP_DELAY_TIMER;
                    end else begin
                        next_state = ST_RUN;
                    end
                end
            end
            ST_POWERUP_DELAY_TIMER: begin
                if (powerup_delay_timer_done) begin
                    next_state = after_powerup_delay_timer(por_seq, cfg.osc_mode);
                end
            end
            ST_OST: begin
                if (ost_done) begin
                    next_state = mode_uses_pll(cfg.osc_mode) ? ST_PLL : ST_RUN;
                end
            end
            ST_PLL: begin
                if (pll_done) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // waking from a power-managed mode reruns the oscillator and lock waits
                if (pm_exit_wake && mode_needs_ost(cfg.osc_mode)) begin
                    next_state = ST_OST;
                end else if (pm_exit_wake && mode_uses_pll(cfg.osc_mode)) begin
                    next_state = ST_PLL;
                end
            end
            default: begin
                next_state = ST_POR;
            end
        endcase
        // brown-out overrides every timer; the timers restart from zero
        if (bor_reset) begin
            next_state = ST_BOR;
        end
        if (por_pulse) begin
            next_state = ST_POR;
        end
    end

    // por_seq remembers a power-on start, which alone earns the oscillator wait after the power-up delay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state   <= ST_POR;
            por_seq <= 1'b1;
        end else begin
            state <= next_state;
            if (por_pulse) begin
                por_seq <= 1'b1;
            end else if (next_state == ST_BOR || next_state == ST_RUN) begin
                por_seq <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparator qualification

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= supply_below_cmp;
            cmp_sync <= cmp_meta;
        end
    end

    // counter saturates so a long low level keeps the trigger asserted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bor_cnt <= '0;
        end else if (!supply_low) begin
            bor_cnt <= '0;
        end else if (bor_cnt != BOR_CNT_W'(BOR_MIN_CYCLES)) begin
            bor_cnt <= bor_cnt + BOR_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lf_q  <= 1'b0;
            osc_q <= 1'b0;
        end else begin
            lf_q  <= low_freq_internal_osc;
            osc_q <= primary_osc_in;
        end
    end

    // leaving the counting state clears the count, so re-entry starts over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            powerup_delay_timer_cnt <= '0;
        end else if (state != ST_POWERUP_DELAY_TIMER) begin
            powerup_delay_timer_cnt <= '0;
        end else if (lf_tick) begin
            powerup_delay_timer_cnt <= powerup_delay_timer_cnt + POWERUP_DELAY_TIMER_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ost_cnt <= '0;
        end else if (state != ST_OST) begin
            ost_cnt <= '0;
        end else if (osc_tick) begin
            ost_cnt <= ost_cnt + OST_CNT_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_cnt <= '0;
        end else if (state != ST_PLL) begin
            pll_cnt <= '0;
        end else begin
            pll_cnt <= pll_cnt + PLL_CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags; hardware clears beat a software set in the same cycle

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poweron_flag_n <= RST_POR_FLAG;
        end else if (por_pulse) begin
            poweron_flag_n <= 1'b0;
        end else if (set_poweron) begin
            poweron_flag_n <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brownout_flag_n <= RST_BOR_FLAG;
        end else if (por_pulse && det_enable) begin
            brownout_flag_n <= 1'b0;
        end else if (bor_reset) begin
            brownout_flag_n <= 1'b0;
        end else if (set_brownout) begin
            brownout_flag_n <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_brownout_enable <= RST_SW_BOR_EN;
        end else if (por_pulse) begin
            sw_brownout_enable <= RST_SW_BOR_EN;
        end else if (wr_ctrl && sw_mode) begin
            sw_brownout_enable <= pwdata[BIT_SW_BOR_EN];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    // master clear gates release only; the timers above never look at it
    wire logic next_hold = (next_state != ST_RUN) | ~master_clear_n;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_out <= '{core_reset_hold: 1'b1,
                            detector_enable: 1'b0,
                            brownout_threshold: 2'h0};
        end else begin
            status_out.core_reset_hold    <= next_hold;
            status_out.detector_enable    <= det_enable;
            status_out.brownout_threshold <= cfg.brownout_threshold_select;
        end
    end

    // read data is zero outside the answer cycle, so a stale word never leaks out
    wire logic        next_pslverr = acc & ~(hit_ctrl | hit_stat);
    wire logic [31:0] next_prdata  = (acc & ~pwrite) ? rd_word : 32'h0000_0000;

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= acc;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

endmodule

/* File: tb/bst_props.sv */
module bst_props
    import bst_pkg::*;
#(
    parameter int PLL_WAIT_CYC = 20
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire bst_pkg::bst_cfg_t cfg,
    input wire logic              por_pulse,
    input wire logic              supply_below_cmp,
    input wire logic              master_clear_n,
    input wire logic              sleep_active,
    input wire logic              pm_exit_wake,
    input wire logic              low_freq_internal_osc,
    input wire logic              primary_osc_in,
    input wire bst_pkg::bst_out_t status_out
);
    // margin covers two sync stages, the state edge and the registered hold
    localparam int LOW_LIMIT = BOR_MIN_CYCLES + 6;
    logic [7:0] low_run;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_run <= 8'h00;
        end else if (por_pulse || !(status_out.detector_enable && supply_below_cmp)) begin
            low_run <= 8'h00;
        end else if (low_run != 8'hff) begin
            low_run <= low_run + 8'h01;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing one cycle into the access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    a_brownout_holds: assert property (low_run >= LOW_LIMIT |-> status_out.core_reset_hold)
        else $error("long supply dip did not hold reset");
    a_clear_holds: assert property (!master_clear_n |=> status_out.core_reset_hold)
        else $error("master clear low did not hold reset");
    a_por_holds: assert property (por_pulse |=> status_out.core_reset_hold)
        else $error("power-on pulse did not hold reset");
    a_thr_follows: assert property ($past(presetn) |->
        status_out.brownout_threshold == $past(cfg.brownout_threshold_select))
        else $error("threshold differs from configuration");
    a_off_no_det: assert property ($past(presetn) &&
        $past(cfg.brownout_enable_mode) == BOR_MODE_OFF |-> !status_out.detector_enable)
        else $error("detector on in mode off");
    a_on_always_det: assert property ($past(presetn) &&
        $past(cfg.brownout_enable_mode) == BOR_MODE_ON |-> status_out.detector_enable)
        else $error("detector off in mode always on");
    a_sleep_det_off: assert property ($past(presetn) &&
        $past(cfg.brownout_enable_mode) == BOR_MODE_NOSLP
        |-> status_out.detector_enable == !$past(sleep_active))
        else $error("detector does not follow sleep");
endmodule

bind bst_brownout_and_startup_timers bst_props #(.PLL_WAIT_CYC(PLL_WAIT_CYC)) u_bst_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cfg(cfg), .por_pulse(por_pulse), .supply_below_cmp(supply_below_cmp),
    .master_clear_n(master_clear_n), .sleep_active(sleep_active),
    .pm_exit_wake(pm_exit_wake), .low_freq_internal_osc(low_freq_internal_osc),
    .primary_osc_in(primary_osc_in), .status_out(status_out)
);

/* File: tb/bst_brownout_and_startup_timers_bench.sv */
module bst_brownout_and_startup_timers_bench
    import bst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PLL_W = 20;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    bst_cfg_t    cfg = {BOR_MODE_SW, 2'h2, 1'b1, OSC_EC};
    logic        por_pulse = 1'b1;
    logic        supply_below_cmp = 1'b0;
    logic        master_clear_n = 1'b1;
    logic        sleep_active = 1'b0;
    logic        pm_exit_wake = 1'b0;
    logic        low_freq_internal_osc = 1'b0;
    logic        primary_osc_in = 1'b0;
    bst_out_t    status_out;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          cyc = 0;
    int          seed = 16;
    logic        m_bor_n = 1'b0;
    logic        m_por_n = 1'b0;
    logic        m_sw = 1'b1;
    logic [31:0] rd;
    logic        err;
    logic [1:0]  thr;
    bst_osc_t    osc_tab [6] = '{OSC_RC, OSC_EC, OSC_XT, OSC_EC, OSC_ECPLL, OSC_HSPLL};
    logic        dis_tab [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
    int          dly_tab [6] = '{0, 8192, 10240, 0, PLL_W, 2048 + PLL_W};

    bst_brownout_and_startup_timers #(.PLL_WAIT_CYC(PLL_W)) u_bst_brownout_and_startup_timers (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cfg(cfg), .por_pulse(por_pulse), .supply_below_cmp(supply_below_cmp),
        .master_clear_n(master_clear_n), .sleep_active(sleep_active),
        .pm_exit_wake(pm_exit_wake), .low_freq_internal_osc(low_freq_internal_osc),
        .primary_osc_in(primary_osc_in), .status_out(status_out)
    );

    always #2.5 pclk = ~pclk;

    // slow oscillator ticks every 4 cycles, primary every 2
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        primary_osc_in <= ~primary_osc_in;
        if (cyc[0]) begin
            low_freq_internal_osc <= ~low_freq_internal_osc;
        end
        if (cyc == 80000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // entered just after a rising edge; request held until pready is sampled
    task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] exp_ctrl();
        return {25'h0, m_sw & (cfg.brownout_enable_mode == BOR_MODE_SW), 4'h0, m_por_n, m_bor_n};
    endfunction

    function automatic logic [31:0] exp_det();
        return {31'h0, cfg.brownout_enable_mode == BOR_MODE_ON
            || (cfg.brownout_enable_mode == BOR_MODE_NOSLP && !sleep_active)
            || (cfg.brownout_enable_mode == BOR_MODE_SW && m_sw)};
    endfunction

    task automatic wr_ctrl(logic [31:0] d);
        apb(1'b1, ADDR_CTRL, d);
        m_bor_n = m_bor_n | d[0];
        m_por_n = m_por_n | d[1];
        if (cfg.brownout_enable_mode == BOR_MODE_SW) begin
            m_sw = d[6];
        end
    endtask

    task automatic power_on(bst_cfg_t c);
        por_pulse <= 1'b1;
        cfg <= c;
        repeat (4) @(posedge pclk);
        m_por_n = 1'b0;
        m_sw = 1'b1;
        if (c.brownout_enable_mode != BOR_MODE_OFF) begin
            m_bor_n = 1'b0;
        end
        por_pulse <= 1'b0;
    endtask

    task automatic wait_release(int exp);
        int n;
        n = 0;
        while (status_out.core_reset_hold !== 1'b0 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        // the first oscillator tick lands anywhere within one period of the state entry
        check("release time", {31'h0, n >= exp - 4 && n <= exp + 8}, 32'h1);
    endtask

    task automatic dip(int len);
        supply_below_cmp <= 1'b1;
        repeat (len) @(posedge pclk);
        check("hold in dip", status_out.core_reset_hold, len > 60);
        supply_below_cmp <= 1'b0;
        if (len > 60) begin
            m_bor_n = 1'b0;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl at reset", rd, exp_ctrl());
        for (int i = 0; i < 6; i++) begin
            power_on({BOR_MODE_OFF, 2'h0, dis_tab[i], osc_tab[i]});
            wait_release(dly_tab[i]);
        end
        pm_exit_wake <= 1'b1;
        @(posedge pclk);
        pm_exit_wake <= 1'b0;
        repeat (4) @(posedge pclk);
        wait_release(2048 + PLL_W - 4);
        for (int m = 0; m < 4; m++) begin
            thr = 2'($random(seed));
            power_on({m[1:0], thr, 1'b1, OSC_EC});
            wait_release(0);
            apb(1'b0, ADDR_CTRL, 32'h0);
            check("ctrl", rd, exp_ctrl());
            apb(1'b0, ADDR_STAT, 32'h0);
            check("detector", rd[STAT_DET_EN], exp_det());
            check("threshold", rd[STAT_THR_LSB +: 2], thr);
            wr_ctrl($random(seed) & 32'hffffffbf);
            apb(1'b1, 12'h008, 32'hffffffff);
            check("unmapped error", err, 1'b1);
            apb(1'b0, ADDR_CTRL, 32'h0);
            check("ctrl after write", rd, exp_ctrl());
            sleep_active <= 1'b1;
            apb(1'b0, ADDR_STAT, 32'h0);
            check("detector asleep", rd[STAT_DET_EN], exp_det());
            sleep_active <= 1'b0;
        end
        wr_ctrl(32'h3);
        dip(20);
        dip(150);
        wait_release(0);
        apb(1'b0, ADDR_CTRL, 32'h0);
        check("ctrl after dip", rd, exp_ctrl());
        power_on({BOR_MODE_ON, 2'h1, 1'b0, OSC_EC});
        wait_release(8192);
        dip(150);
        repeat (4000) @(posedge pclk);
        check("hold in delay", status_out.core_reset_hold, 1'b1);
        dip(150);
        wait_release(8192);
        master_clear_n <= 1'b0;
        power_on({BOR_MODE_OFF, 2'h0, 1'b0, OSC_EC});
        repeat (8300) @(posedge pclk);
        check("hold by clear", status_out.core_reset_hold, 1'b1);
        master_clear_n <= 1'b1;
        wait_release(0);
        tally_and_finish();
    end
endmodule
